// *** core/vitc_top.sv ***
// Chosen here: the register offsets and the APB register port.
module vitc_top (
	input wire logic i_clk, // system clock, 40 MHz
	input wire logic i_sys_rst, // async reset, active high
	input wire logic [vitc_pkg::SRC_NUM-1:0] i_int_src, // peripheral request levels
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb enable
	input wire logic i_pwrite, // apb direction, 1 = write
	input wire logic [vitc_pkg::ADDR_W-1:0] i_paddr, // apb byte address
	input wire logic [vitc_pkg::DATA_W-1:0] i_pwdata, // apb write data
	input wire logic [2:0] i_pprot, // apb protection, bit 0 = privileged
	output logic [vitc_pkg::DATA_W-1:0] o_prdata, // apb read data
	output logic o_pready, // apb ready
	output logic o_pslverr, // apb error
	output logic o_irq, // normal interrupt request to core
	output logic o_fast_interrupt_request, // fast interrupt request to core
	output logic o_evt_int // controller event interrupt
);
	import vitc_pkg::*;

	logic [SRC_NUM-1:0] src_sync;
	logic [SRC_NUM-1:0] enable_reg;
	logic [SRC_NUM-1:0] select_reg;
	logic [SRC_NUM-1:0] soft_reg;
	logic [SRC_NUM-1:0] raw_lines;
	logic [SRC_NUM-1:0] irq_lines;
	logic [SRC_NUM-1:0] fast_lines;
	logic protect_reg;
	logic [31:0] def_vect_reg;
	logic [31:0] cur_vect_reg;
	logic [31:0] cur_vect_next;
	logic [31:0] vect_addr_reg [SLOT_NUM];
	logic [VCTRL_W-1:0] vect_ctrl_reg [SLOT_NUM];
	logic [EVT_NUM-1:0] evt_stat_reg;
	logic [EVT_NUM-1:0] evt_mask_reg;
	logic [EVT_NUM-1:0] evt_set;
	logic setup;
	logic access;
	logic wr;
	logic viol;
	logic addr_hit;
	logic [31:0] rd_word;
	logic [SLOT_IDX_W-1:0] slot_idx;

	// peripherals may run on their own clocks, so every line is filtered
	vitc_sync #(
		.W(SRC_NUM)
	) u_sync (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_int_src),
		.o_sync(src_sync)
	);

	assign raw_lines = src_sync | soft_reg;
	assign irq_lines = raw_lines & enable_reg & ~select_reg;
	assign fast_lines = raw_lines & enable_reg & select_reg;

	// lowest slot is visited last, so it overrides higher ones
	always_comb begin
		cur_vect_next = def_vect_reg;
		for (int i = SLOT_NUM - 1; i >= 0; i--) begin
			if (vect_ctrl_reg[i][VCTRL_EN_BIT] &&
				irq_lines[vect_ctrl_reg[i][SRC_IDX_W-1:0]]) begin
				cur_vect_next = vect_addr_reg[i];
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_irq <= 1'b0;
			o_fast_interrupt_request <= 1'b0;
			cur_vect_reg <= RST_WORD;
		end else begin
			o_irq <= |irq_lines;
			o_fast_interrupt_request <= |fast_lines;
			cur_vect_reg <= cur_vect_next;
		end
	end

	// apb: setup captures the answer, the next cycle is the single access cycle
	assign setup = i_psel & ~i_penable;
	assign access = i_psel & i_penable & o_pready;
	assign viol = protect_reg & ~i_pprot[0];
	assign wr = access & i_pwrite & ~o_pslverr;
	assign slot_idx = i_paddr[5:2];

	always_comb begin
		addr_hit = 1'b1;
		rd_word = RST_WORD;
		if (i_paddr == OFS_IRQ_STAT_LO) begin
			rd_word = irq_lines[31:0];
		end else if (i_paddr == OFS_IRQ_STAT_HI) begin
			rd_word = irq_lines[63:32];
		end else if (i_paddr == OFS_FAST_STAT_LO) begin
			rd_word = fast_lines[31:0];
		end else if (i_paddr == OFS_FAST_STAT_HI) begin
			rd_word = fast_lines[63:32];
		end else if (i_paddr == OFS_RAW_LO) begin
			rd_word = raw_lines[31:0];
		end else if (i_paddr == OFS_RAW_HI) begin
			rd_word = raw_lines[63:32];
		end else if (i_paddr == OFS_SELECT_LO) begin
			rd_word = select_reg[31:0];
		end else if (i_paddr == OFS_SELECT_HI) begin
			rd_word = select_reg[63:32];
		end else if (i_paddr == OFS_ENABLE_LO) begin
			rd_word = enable_reg[31:0];
		end else if (i_paddr == OFS_ENABLE_HI) begin
			rd_word = enable_reg[63:32];
		end else if (i_paddr == OFS_SOFT_LO) begin
			rd_word = soft_reg[31:0];
		end else if (i_paddr == OFS_SOFT_HI) begin
			rd_word = soft_reg[63:32];
		end else if (i_paddr == OFS_PROTECT) begin
			rd_word = {31'h0000_0000, protect_reg};
		end else if (i_paddr == OFS_CUR_VECT) begin
			rd_word = cur_vect_reg;
		end else if (i_paddr == OFS_DEF_VECT) begin
			rd_word = def_vect_reg;
		end else if (i_paddr == OFS_EVT_STAT) begin
			rd_word = {29'h0000_0000, evt_stat_reg};
		end else if (i_paddr == OFS_EVT_MASK) begin
			rd_word = {29'h0000_0000, evt_mask_reg};
		end else if (i_paddr[11:8] == PAGE_VECT_ADDR && i_paddr[7:6] == 2'h0 &&
			i_paddr[1:0] == 2'h0) begin
			rd_word = vect_addr_reg[slot_idx];
		end else if (i_paddr[11:8] == PAGE_VECT_CTRL && i_paddr[7:6] == 2'h0 &&
			i_paddr[1:0] == 2'h0) begin
			rd_word = {25'h000_0000, vect_ctrl_reg[slot_idx]};
		end else begin
			addr_hit = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= RST_WORD;
		end else begin
			o_pready <= setup;
			o_pslverr <= setup & (~addr_hit | viol);
			if (setup) begin
				// user access to a protected controller reads as zero
				o_prdata <= (viol || i_pwrite) ? RST_WORD : rd_word;
			end
		end
	end

	// line configuration; a write of the status or raw words has no effect
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			enable_reg <= RST_LINES;
		end else if (wr && i_paddr == OFS_ENABLE_LO) begin
			enable_reg[31:0] <= i_pwdata;
		end else if (wr && i_paddr == OFS_ENABLE_HI) begin
			enable_reg[63:32] <= i_pwdata;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			select_reg <= RST_LINES;
		end else if (wr && i_paddr == OFS_SELECT_LO) begin
			select_reg[31:0] <= i_pwdata;
		end else if (wr && i_paddr == OFS_SELECT_HI) begin
			select_reg[63:32] <= i_pwdata;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			soft_reg <= RST_LINES;
		end else if (wr && i_paddr == OFS_SOFT_LO) begin
			soft_reg[31:0] <= i_pwdata;
		end else if (wr && i_paddr == OFS_SOFT_HI) begin
			soft_reg[63:32] <= i_pwdata;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			protect_reg <= 1'b0;
		end else if (wr && i_paddr == OFS_PROTECT) begin
			protect_reg <= i_pwdata[0];
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			def_vect_reg <= RST_WORD;
		end else if (wr && i_paddr == OFS_DEF_VECT) begin
			def_vect_reg <= i_pwdata;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			for (int i = 0; i < SLOT_NUM; i++) begin
				vect_addr_reg[i] <= RST_WORD;
				vect_ctrl_reg[i] <= RST_VCTRL;
			end
		end else if (wr && i_paddr[7:6] == 2'h0 && i_paddr[1:0] == 2'h0) begin
			if (i_paddr[11:8] == PAGE_VECT_ADDR) begin
				vect_addr_reg[slot_idx] <= i_pwdata;
			end else if (i_paddr[11:8] == PAGE_VECT_CTRL) begin
				vect_ctrl_reg[slot_idx] <= i_pwdata[VCTRL_W-1:0];
			end
		end
	end

	// controller events: sticky, write one to clear, a new event beats the clear
	always_comb begin
		evt_set = RST_EVT;
		evt_set[EVT_IRQ_RISE] = (|irq_lines) & ~o_irq;
		evt_set[EVT_FAST_RISE] = (|fast_lines) & ~o_fast_interrupt_request;
		evt_set[EVT_PROT_VIOL] = setup & viol;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			evt_stat_reg <= RST_EVT;
		end else if (wr && i_paddr == OFS_EVT_STAT) begin
			evt_stat_reg <= (evt_stat_reg & ~i_pwdata[EVT_NUM-1:0]) | evt_set;
		end else begin
			evt_stat_reg <= evt_stat_reg | evt_set;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			evt_mask_reg <= RST_EVT;
		end else if (wr && i_paddr == OFS_EVT_MASK) begin
			evt_mask_reg <= i_pwdata[EVT_NUM-1:0];
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_evt_int <= 1'b0;
		end else begin
			o_evt_int <= |(evt_stat_reg & evt_mask_reg);
		end
	end
endmodule // vitc_top

// *** core/vitc_pkg.sv ***
package vitc_pkg;
	localparam int SRC_NUM = 64;
	localparam int SLOT_NUM = 16;
	localparam int SRC_IDX_W = 6;
	localparam int SLOT_IDX_W = 4;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int EVT_NUM = 3;

	// register byte offsets
	localparam logic [11:0] OFS_IRQ_STAT_LO = 12'h000;
	localparam logic [11:0] OFS_IRQ_STAT_HI = 12'h004;
	localparam logic [11:0] OFS_FAST_STAT_LO = 12'h008;
	localparam logic [11:0] OFS_FAST_STAT_HI = 12'h00C;
	localparam logic [11:0] OFS_RAW_LO = 12'h010;
	localparam logic [11:0] OFS_RAW_HI = 12'h014;
	localparam logic [11:0] OFS_SELECT_LO = 12'h018;
	localparam logic [11:0] OFS_SELECT_HI = 12'h01C;
	localparam logic [11:0] OFS_ENABLE_LO = 12'h020;
	localparam logic [11:0] OFS_ENABLE_HI = 12'h024;
	localparam logic [11:0] OFS_SOFT_LO = 12'h028;
	localparam logic [11:0] OFS_SOFT_HI = 12'h02C;
	localparam logic [11:0] OFS_PROTECT = 12'h030;
	localparam logic [11:0] OFS_CUR_VECT = 12'h034;
	localparam logic [11:0] OFS_DEF_VECT = 12'h038;
	localparam logic [11:0] OFS_EVT_STAT = 12'h03C;
	localparam logic [11:0] OFS_EVT_MASK = 12'h040;
	// slot n: vector address at 0x100 + 4n, slot control at 0x200 + 4n
	localparam logic [3:0] PAGE_VECT_ADDR = 4'h1;
	localparam logic [3:0] PAGE_VECT_CTRL = 4'h2;

	// slot control fields
	localparam int VCTRL_EN_BIT = 6;
	localparam int VCTRL_W = 7;

	// event status bit positions
	localparam int EVT_IRQ_RISE = 0;
	localparam int EVT_FAST_RISE = 1;
	localparam int EVT_PROT_VIOL = 2;

	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [63:0] RST_LINES = 64'h0000_0000_0000_0000;
	localparam logic [6:0] RST_VCTRL = 7'h00;
	localparam logic [2:0] RST_EVT = 3'h0;
	localparam logic [2:0] RST_SYNC = 3'h0;
endpackage : vitc_pkg

// *** core/vitc_sync.sv ***
// three-stage synchroniser: a new level is taken once stages two and three agree
module vitc_sync #(
	parameter int W = 64
) (
	input wire logic i_clk, // system clock
	input wire logic i_sys_rst, // async reset, active high
	input wire logic [W-1:0] i_async, // levels from other domains
	output logic [W-1:0] o_sync // filtered level
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			o_sync <= '0;
		end else begin
			s1_reg <= i_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < W; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					o_sync[i] <= s3_reg[i];
				end
			end
		end
	end
endmodule // vitc_sync

// *** testbench/vitc_props.sv ***
module vitc_props (
	input wire logic i_clk, // system clock
	input wire logic i_sys_rst, // async reset
	input wire logic [vitc_pkg::SRC_NUM-1:0] i_int_src, // request lines
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb enable
	input wire logic [vitc_pkg::DATA_W-1:0] o_prdata, // read data
	input wire logic o_pready, // apb ready
	input wire logic o_pslverr, // apb error
	input wire logic o_irq, // normal request
	input wire logic o_fast_interrupt_request // fast request
);
	timeunit 1ns;
	timeprecision 1ps;
	import vitc_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_setup; i_psel && !i_penable; endsequence
	sequence s_access; i_psel && i_penable && o_pready; endsequence
	property p_setup_ready; s_setup |=> s_access; endproperty
	a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
	property p_ready_cause; o_pready |-> $past(i_psel && !i_penable); endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
	property p_ready_once; o_pready |=> !o_pready; endproperty
	a_ready_once: assert property (p_ready_once) else $error("ready too long");
	property p_err_ready; o_pslverr |-> o_pready; endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	property p_err_once; o_pslverr |=> !o_pslverr; endproperty
	a_err_once: assert property (p_err_once) else $error("error too long");
	property p_data_hold; !o_pready |-> $stable(o_prdata); endproperty
	a_data_hold: assert property (p_data_hold) else $error("read data moved");
	// a request may only rise after an apb transfer (read or write) or a source that was high
	property p_irq_cause;
		$rose(o_irq) |-> $past(o_pready, 2) || (|($past(i_int_src, 4) | $past(i_int_src, 5)));
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("normal request uncaused");
	property p_fast_cause;
		$rose(o_fast_interrupt_request) |->
			$past(o_pready, 2) || (|($past(i_int_src, 4) | $past(i_int_src, 5)));
	endproperty
	a_fast_cause: assert property (p_fast_cause) else $error("fast request uncaused");
endmodule // vitc_props

bind vitc_top vitc_props i_props (.i_clk, .i_sys_rst, .i_int_src, .i_psel, .i_penable,
	.o_prdata, .o_pready, .o_pslverr, .o_irq, .o_fast_interrupt_request);

// *** testbench/vitc_core_model.sv ***
module vitc_core_model (
	input wire logic i_clk, // system clock
	input wire logic i_sys_rst, // async reset
	input wire logic i_irq, // normal request level
	input wire logic i_fast, // fast request level
	output int o_irq_cnt, // normal requests taken
	output int o_fast_cnt // fast requests taken
);
	timeunit 1ns;
	timeprecision 1ps;
	logic irq_reg;
	logic fast_reg;
	// the core enters a handler on each rising level, so counting edges shows glitches
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			irq_reg <= 1'b0;
			fast_reg <= 1'b0;
			o_irq_cnt <= 0;
			o_fast_cnt <= 0;
		end else begin
			irq_reg <= i_irq;
			fast_reg <= i_fast;
			o_irq_cnt <= o_irq_cnt + int'(i_irq && !irq_reg);
			o_fast_cnt <= o_fast_cnt + int'(i_fast && !fast_reg);
		end
	end
endmodule // vitc_core_model

// *** testbench/testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import vitc_pkg::*;
	logic i_clk = 0, i_sys_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, err;
	logic [SRC_NUM-1:0] i_int_src = '0;
	logic [11:0] i_paddr = '0;
	logic [31:0] i_pwdata = '0, o_prdata, rd;
	logic [2:0] i_pprot = 3'h1;
	logic o_pready, o_pslverr, o_irq, o_fast, o_evt_int;
	int miscompares = 0, comparisons = 0, cyc = 0, n_irq, n_fast;
	always #12.5 i_clk = ~i_clk;
	vitc_top i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_int_src(i_int_src),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .i_pprot(i_pprot), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .o_irq(o_irq), .o_fast_interrupt_request(o_fast),
		.o_evt_int(o_evt_int));
	vitc_core_model i_core (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_irq(o_irq),
		.i_fast(o_fast), .o_irq_cnt(n_irq), .o_fast_cnt(n_fast));
	task give_verdict;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	// answers are read right at the edge, before the design's registers move
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		do @(posedge i_clk); while (o_pready !== 1'b1);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		// line outputs lag a write by one edge; let them settle before callers look
		repeat (2) @(posedge i_clk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, RST_WORD);
		chk(rd, e);
	endtask
	task t_reset;
		rdc(OFS_ENABLE_LO, RST_WORD);
		rdc(OFS_SELECT_HI, RST_WORD);
		rdc(12'h044, RST_WORD);
		chk({31'h0, err}, 32'h1);
		$display("test done: reset");
	endtask
	task t_soft;
		wr(OFS_SOFT_HI, 32'h0000_0020);
		chk({31'h0, o_irq}, 32'h0);
		wr(OFS_ENABLE_HI, 32'h0000_0020);
		chk({31'h0, o_irq}, 32'h1);
		rdc(OFS_IRQ_STAT_HI, 32'h0000_0020);
		wr(OFS_SELECT_HI, 32'h0000_0020);
		chk({30'h0, o_irq, o_fast}, 32'h1);
		rdc(OFS_FAST_STAT_HI, 32'h0000_0020);
		chk(32'(n_fast), 32'h1);
		chk(32'(n_irq), 32'h1);
		rdc(OFS_EVT_STAT, 32'h0000_0003);
		wr(OFS_EVT_STAT, 32'h0000_0003);
		rdc(OFS_EVT_STAT, RST_WORD);
		wr(OFS_SOFT_HI, RST_WORD);
		$display("test done: soft");
	endtask
	task t_src;
		wr(OFS_ENABLE_LO, 32'h0000_0001);
		wr(OFS_ENABLE_HI, 32'h8000_0000);
		wr(OFS_SELECT_HI, 32'h8000_0000);
		i_int_src <= 64'h8000_0000_0000_0001;
		repeat (8) @(posedge i_clk);
		chk({30'h0, o_irq, o_fast}, 32'h3);
		rdc(OFS_RAW_HI, 32'h8000_0000);
		i_int_src <= '0;
		repeat (8) @(posedge i_clk);
		chk({30'h0, o_irq, o_fast}, 32'h0);
		$display("test done: sources");
	endtask
	task t_vect;
		wr({PAGE_VECT_ADDR, 8'h0C}, 32'h0000_A300);
		wr({PAGE_VECT_ADDR, 8'h3C}, 32'h0000_AF00);
		wr({PAGE_VECT_CTRL, 8'h0C}, 32'h0000_0042);
		wr({PAGE_VECT_CTRL, 8'h3C}, 32'h0000_0041);
		wr(OFS_DEF_VECT, 32'h0000_DEF0);
		wr(OFS_ENABLE_LO, 32'h0000_0006);
		wr(OFS_SOFT_LO, 32'h0000_0006);
		rdc(OFS_CUR_VECT, 32'h0000_A300);
		wr(OFS_SOFT_LO, 32'h0000_0002);
		rdc(OFS_CUR_VECT, 32'h0000_AF00);
		wr(OFS_SOFT_LO, RST_WORD);
		rdc(OFS_CUR_VECT, 32'h0000_DEF0);
		$display("test done: vectors");
	endtask
	task t_prot;
		wr(OFS_EVT_MASK, 32'h0000_0004);
		wr(OFS_PROTECT, 32'h0000_0001);
		i_pprot <= 3'h0;
		rdc(OFS_ENABLE_LO, RST_WORD);
		chk({31'h0, err}, 32'h1);
		wr(OFS_PROTECT, RST_WORD);
		chk({31'h0, err}, 32'h1);
		i_pprot <= 3'h1;
		rdc(OFS_PROTECT, 32'h0000_0001);
		chk({31'h0, o_evt_int}, 32'h1);
		wr(OFS_EVT_STAT, 32'h0000_0004);
		chk({31'h0, o_evt_int}, 32'h0);
		$display("test done: protection");
	endtask
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			give_verdict;
		end
	end
	initial begin
		repeat (3) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		t_reset;
		t_soft;
		t_src;
		t_vect;
		t_prot;
		give_verdict;
	end
endmodule // testbench
